// >>> shared/bhc_pkg.sv
// Shared constants and state type of the byte handshake link
package bhc_pkg;
    localparam int          WORD_W         = 32;
    localparam int          BYTE_W         = 8;
    localparam logic [1:0]  LAST_BYTE      = 2'h3;
    localparam logic [1:0]  FIRST_BYTE     = 2'h0;
    localparam int          FIRST_IN_PORT  = 3;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          TAKE_TIME_NS   = 16;
    localparam int          TAKE_CYCLES_I  =
        (TAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0]  TAKE_CYCLES    = 3'(TAKE_CYCLES_I);
    localparam logic [2:0]  TAKE_ZERO      = 3'h0;
    localparam logic        LINE_IDLE      = 1'b1;
    localparam logic        LINE_ACTIVE    = 1'b0;

    typedef enum logic [7:0] {
        BHC_OIDLE    = 8'h01,
        BHC_OSETUP   = 8'h02,
        BHC_OSTROBE  = 8'h04,
        BHC_ORELEASE = 8'h08,
        BHC_GRANT    = 8'h10,
        BHC_IIDLE    = 8'h20,
        BHC_IREQ     = 8'h40,
        BHC_TAKE     = 8'h80
    } bhc_state_t;
endpackage

// >>> shared/bhc_link_if.sv
// Link pins between the device end and the far end, with wire resolution
`timescale 1ns/1ns
interface bhc_link_if;
    logic       dev_token_request_o,   dev_token_request_oe;
    logic       dev_token_acknowledge_o, dev_token_acknowledge_oe;
    logic       dev_byte_strobe_o,     dev_byte_strobe_oe;
    logic       dev_byte_ready_o,      dev_byte_ready_oe;
    logic [7:0] dev_port_byte_lines_o;
    logic       dev_port_byte_lines_oe;
    logic       far_token_request_o,   far_token_request_oe;
    logic       far_token_acknowledge_o, far_token_acknowledge_oe;
    logic       far_byte_strobe_o,     far_byte_strobe_oe;
    logic       far_byte_ready_o,      far_byte_ready_oe;
    logic [7:0] far_port_byte_lines_o;
    logic       far_port_byte_lines_oe;
    logic       token_request;
    logic       token_acknowledge;
    logic       byte_strobe;
    logic       byte_ready;
    logic [7:0] port_byte_lines;

    // Undriven lines rest high as if pulled up
    assign token_request = dev_token_request_oe ? dev_token_request_o :
        (far_token_request_oe ? far_token_request_o : 1'b1);
    assign token_acknowledge = dev_token_acknowledge_oe ?
        dev_token_acknowledge_o :
        (far_token_acknowledge_oe ? far_token_acknowledge_o : 1'b1);
    assign byte_strobe = dev_byte_strobe_oe ? dev_byte_strobe_o :
        (far_byte_strobe_oe ? far_byte_strobe_o : 1'b1);
    assign byte_ready = dev_byte_ready_oe ? dev_byte_ready_o :
        (far_byte_ready_oe ? far_byte_ready_o : 1'b1);
    assign port_byte_lines = dev_port_byte_lines_oe ?
        dev_port_byte_lines_o :
        (far_port_byte_lines_oe ? far_port_byte_lines_o : 8'hFF);

    modport dev_mp (
        output dev_token_request_o, dev_token_request_oe,
        output dev_token_acknowledge_o, dev_token_acknowledge_oe,
        output dev_byte_strobe_o, dev_byte_strobe_oe,
        output dev_byte_ready_o, dev_byte_ready_oe,
        output dev_port_byte_lines_o, dev_port_byte_lines_oe,
        input  token_request, token_acknowledge, byte_strobe,
        input  byte_ready, port_byte_lines
    );
    modport far_mp (
        output far_token_request_o, far_token_request_oe,
        output far_token_acknowledge_o, far_token_acknowledge_oe,
        output far_byte_strobe_o, far_byte_strobe_oe,
        output far_byte_ready_o, far_byte_ready_oe,
        output far_port_byte_lines_o, far_port_byte_lines_oe,
        input  token_request, token_acknowledge, byte_strobe,
        input  byte_ready, port_byte_lines
    );
endinterface // bhc_link_if

// >>> rtl/bhc_dev_port.sv
// Device end of one byte handshake communication port
// Function
// - Word is four byte transfers from byte 0
// - Byte valid on lines before strobe falls
// - Receiver drops ready after strobe falls
// - Sender raises strobe only after ready low
// - Sender holds byte until ready is low
// - Receiver raises ready after strobe rises
// - Later bytes wait for ready high
// - Next word starts after last ready high
// - No timeout on any handshake wait
// - Ports 0-2 reset as outputs, 3-5 inputs
// - Lines float while reset is held
// - After reset, role lines are driven high
// - Reset taken any time, may slip one cycle
// - Token exchange reverses all line directions
// - Request low, acknowledge low, holder releases
// - Far end handshake lines treated as asynchronous
`timescale 1ns/1ns
module bhc_dev_port #(
    parameter int PORT_NUM = 0
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    bhc_link_if.dev_mp                      link,
    input  wire logic                       tx_valid_i,
    input  wire logic [bhc_pkg::WORD_W-1:0] tx_data_i,
    output logic                            tx_ready_o,
    output logic                            rx_valid_o,
    output logic [bhc_pkg::WORD_W-1:0]      rx_data_o,
    input  wire logic                       want_token_i,
    output logic                            holds_token_o
);
    import bhc_pkg::*;

    localparam bhc_state_t START_STATE =
        (PORT_NUM < FIRST_IN_PORT) ? BHC_OIDLE : BHC_IIDLE;

    bhc_state_t                state;
    bhc_state_t                next_state;
    logic                      live;
    logic [3:0]                sync_a;
    logic [3:0]                sync_b;
    logic [3:0]                raw_in;
    logic                      treq_s;
    logic                      tack_s;
    logic                      strb_s;
    logic                      rdy_s;
    logic [WORD_W-1:0]         tx_shift;
    logic [1:0]                tx_cnt;
    logic [WORD_W-1:0]         rx_word;
    logic [1:0]                rx_cnt;
    logic                      rx_hold;
    logic [BYTE_W-1:0]         rx_byte;
    logic [2:0]                take_cnt;
    logic                      role_out;
    logic                      role_in;

    // Far end lines are asynchronous to this clock
    assign raw_in = {link.token_request, link.token_acknowledge,
                     link.byte_strobe, link.byte_ready};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (srst_i) begin
                    sync_a[gi] <= LINE_IDLE;
                    sync_b[gi] <= LINE_IDLE;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    assign treq_s = sync_b[3];
    assign tack_s = sync_b[2];
    assign strb_s = sync_b[1];
    assign rdy_s  = sync_b[0];

    // Byte lines are stable while strobe is low, so no synchroniser
    assign rx_byte = link.port_byte_lines;

    assign role_out = (state == BHC_OIDLE) || (state == BHC_OSETUP) ||
                      (state == BHC_OSTROBE) || (state == BHC_ORELEASE) ||
                      (state == BHC_GRANT);
    assign role_in  = (state == BHC_IIDLE) || (state == BHC_IREQ);

    // Reset is sampled on the clock, costing at most one extra cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            BHC_OIDLE: begin
                if (treq_s == LINE_ACTIVE) begin
                    next_state = BHC_GRANT;
                end else if (tx_valid_i) begin
                    next_state = BHC_OSETUP;
                end
            end
            BHC_OSETUP: begin
                next_state = BHC_OSTROBE;
            end
            BHC_OSTROBE: begin
                if (rdy_s == LINE_ACTIVE) begin
                    next_state = BHC_ORELEASE;
                end
            end
            BHC_ORELEASE: begin
                if (rdy_s == LINE_IDLE) begin
                    next_state = (tx_cnt == LAST_BYTE) ?
                                 BHC_OIDLE : BHC_OSETUP;
                end
            end
            BHC_GRANT: begin
                if (treq_s == LINE_IDLE) begin
                    next_state = BHC_IIDLE;
                end
            end
            BHC_IIDLE: begin
                if (want_token_i && !rx_hold && rx_cnt == FIRST_BYTE) begin
                    next_state = BHC_IREQ;
                end
            end
            BHC_IREQ: begin
                if (tack_s == LINE_ACTIVE && !rx_hold &&
                    rx_cnt == FIRST_BYTE) begin
                    next_state = BHC_TAKE;
                end
            end
            BHC_TAKE: begin
                if (take_cnt == TAKE_ZERO) begin
                    next_state = BHC_OIDLE;
                end
            end
            default: begin
                next_state = START_STATE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= START_STATE;
        end else begin
            state <= next_state;
        end
    end

    // Wait for the old holder to let go of acknowledge before driving it
    always_ff @(posedge clk_i) begin
        if (srst_i || state != BHC_TAKE) begin
            take_cnt <= TAKE_CYCLES;
        end else if (take_cnt != TAKE_ZERO) begin
            take_cnt <= take_cnt - 3'h1;
        end
    end

    // Transmit shifter, low byte leaves first
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_shift <= '0;
            tx_cnt   <= FIRST_BYTE;
        end else if (state == BHC_OIDLE && next_state == BHC_OSETUP) begin
            tx_shift <= tx_data_i;
            tx_cnt   <= FIRST_BYTE;
        end else if (state == BHC_ORELEASE && next_state == BHC_OSETUP) begin
            tx_shift <= {{BYTE_W{1'b0}}, tx_shift[WORD_W-1:BYTE_W]};
            tx_cnt   <= tx_cnt + 2'h1;
        end
    end

    // Receive side: ready follows the strobe in input role
    always_ff @(posedge clk_i) begin
        if (srst_i || !role_in) begin
            rx_hold <= 1'b0;
            rx_cnt  <= FIRST_BYTE;
        end else if (!rx_hold && strb_s == LINE_ACTIVE) begin
            rx_hold <= 1'b1;
        end else if (rx_hold && strb_s == LINE_IDLE) begin
            rx_hold <= 1'b0;
            rx_cnt  <= rx_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_word <= '0;
        end else if (role_in && !rx_hold && strb_s == LINE_ACTIVE) begin
            rx_word <= {rx_byte, rx_word[WORD_W-1:BYTE_W]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o  <= '0;
        end else begin
            rx_valid_o <= 1'b0;
            if (role_in && rx_hold && strb_s == LINE_IDLE &&
                rx_cnt == LAST_BYTE) begin
                rx_valid_o <= 1'b1;
                rx_data_o  <= rx_word;
            end
        end
    end

    // Pin drive follows role; nothing is driven during reset
    assign link.dev_token_acknowledge_oe = live && role_out;
    assign link.dev_token_acknowledge_o  = (state != BHC_GRANT);
    assign link.dev_byte_strobe_oe       = live && role_out;
    assign link.dev_byte_strobe_o        = (state != BHC_OSTROBE);
    assign link.dev_port_byte_lines_oe   = live && role_out;
    assign link.dev_port_byte_lines_o    = tx_shift[BYTE_W-1:0];
    assign link.dev_token_request_oe     = live && !role_out;
    assign link.dev_token_request_o      = (state != BHC_IREQ);
    assign link.dev_byte_ready_oe        = live && role_in;
    assign link.dev_byte_ready_o         = !rx_hold;

    assign tx_ready_o    = live && (state == BHC_OIDLE) &&
                           (treq_s == LINE_IDLE);
    assign holds_token_o = live && role_out;
endmodule // bhc_dev_port

// >>> rtl/bhc_far_port.sv
// Far end of a byte handshake communication port, acting as a peer
`timescale 1ns/1ns
module bhc_far_port #(
    parameter bit START_OUTPUT = 1'b0
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    bhc_link_if.far_mp                      link,
    input  wire logic                       tx_valid_i,
    input  wire logic [bhc_pkg::WORD_W-1:0] tx_data_i,
    output logic                            tx_ready_o,
    output logic                            rx_valid_o,
    output logic [bhc_pkg::WORD_W-1:0]      rx_data_o,
    input  wire logic                       want_token_i,
    output logic                            holds_token_o
);
    import bhc_pkg::*;

    localparam bhc_state_t START_STATE = START_OUTPUT ? BHC_OIDLE : BHC_IIDLE;

    bhc_state_t        state;
    bhc_state_t        next_state;
    logic              live;
    logic [WORD_W-1:0] tx_shift;
    logic [1:0]        tx_cnt;
    logic [WORD_W-1:0] rx_word;
    logic [1:0]        rx_cnt;
    logic              rx_hold;
    logic [2:0]        take_cnt;
    logic              role_out;
    logic              role_in;

    assign role_out = (state == BHC_OIDLE) || (state == BHC_OSETUP) ||
                      (state == BHC_OSTROBE) || (state == BHC_ORELEASE) ||
                      (state == BHC_GRANT);
    assign role_in  = (state == BHC_IIDLE) || (state == BHC_IREQ);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            live <= 1'b0;
        end else begin
            live <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            BHC_OIDLE: begin
                if (link.token_request == LINE_ACTIVE) begin
                    next_state = BHC_GRANT;
                end else if (tx_valid_i) begin
                    next_state = BHC_OSETUP;
                end
            end
            BHC_OSETUP: begin
                next_state = BHC_OSTROBE;
            end
            BHC_OSTROBE: begin
                if (link.byte_ready == LINE_ACTIVE) begin
                    next_state = BHC_ORELEASE;
                end
            end
            BHC_ORELEASE: begin
                if (link.byte_ready == LINE_IDLE) begin
                    next_state = (tx_cnt == LAST_BYTE) ?
                                 BHC_OIDLE : BHC_OSETUP;
                end
            end
            BHC_GRANT: begin
                if (link.token_request == LINE_IDLE) begin
                    next_state = BHC_IIDLE;
                end
            end
            BHC_IIDLE: begin
                if (want_token_i && !rx_hold && rx_cnt == FIRST_BYTE) begin
                    next_state = BHC_IREQ;
                end
            end
            BHC_IREQ: begin
                if (link.token_acknowledge == LINE_ACTIVE && !rx_hold &&
                    rx_cnt == FIRST_BYTE) begin
                    next_state = BHC_TAKE;
                end
            end
            BHC_TAKE: begin
                if (take_cnt == TAKE_ZERO) begin
                    next_state = BHC_OIDLE;
                end
            end
            default: begin
                next_state = START_STATE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= START_STATE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || state != BHC_TAKE) begin
            take_cnt <= TAKE_CYCLES;
        end else if (take_cnt != TAKE_ZERO) begin
            take_cnt <= take_cnt - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_shift <= '0;
            tx_cnt   <= FIRST_BYTE;
        end else if (state == BHC_OIDLE && next_state == BHC_OSETUP) begin
            tx_shift <= tx_data_i;
            tx_cnt   <= FIRST_BYTE;
        end else if (state == BHC_ORELEASE && next_state == BHC_OSETUP) begin
            tx_shift <= {{BYTE_W{1'b0}}, tx_shift[WORD_W-1:BYTE_W]};
            tx_cnt   <= tx_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !role_in) begin
            rx_hold <= 1'b0;
            rx_cnt  <= FIRST_BYTE;
        end else if (!rx_hold && link.byte_strobe == LINE_ACTIVE) begin
            rx_hold <= 1'b1;
        end else if (rx_hold && link.byte_strobe == LINE_IDLE) begin
            rx_hold <= 1'b0;
            rx_cnt  <= rx_cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_word    <= '0;
            rx_valid_o <= 1'b0;
            rx_data_o  <= '0;
        end else begin
            rx_valid_o <= 1'b0;
            if (role_in && !rx_hold && link.byte_strobe == LINE_ACTIVE) begin
                rx_word <= {link.port_byte_lines, rx_word[WORD_W-1:BYTE_W]};
            end
            if (role_in && rx_hold && link.byte_strobe == LINE_IDLE &&
                rx_cnt == LAST_BYTE) begin
                rx_valid_o <= 1'b1;
                rx_data_o  <= rx_word;
            end
        end
    end

    assign link.far_token_acknowledge_oe = live && role_out;
    assign link.far_token_acknowledge_o  = (state != BHC_GRANT);
    assign link.far_byte_strobe_oe       = live && role_out;
    assign link.far_byte_strobe_o        = (state != BHC_OSTROBE);
    assign link.far_port_byte_lines_oe   = live && role_out;
    assign link.far_port_byte_lines_o    = tx_shift[BYTE_W-1:0];
    assign link.far_token_request_oe     = live && !role_out;
    assign link.far_token_request_o      = (state != BHC_IREQ);
    assign link.far_byte_ready_oe        = live && role_in;
    assign link.far_byte_ready_o         = !rx_hold;

    assign tx_ready_o    = live && (state == BHC_OIDLE) &&
                           (link.token_request == LINE_IDLE);
    assign holds_token_o = live && role_out;
endmodule // bhc_far_port

// >>> testbench/bhc_link_properties.sv
// Pin level checks on the link between the two port ends
`timescale 1ns/1ns
module bhc_link_properties (
    input wire logic       clk_i,
    input wire logic       srst_i,
    input wire logic       token_request,
    input wire logic       token_acknowledge,
    input wire logic       byte_strobe,
    input wire logic       byte_ready,
    input wire logic       dev_token_request_oe,
    input wire logic       dev_token_acknowledge_o,
    input wire logic       dev_token_acknowledge_oe,
    input wire logic       dev_byte_strobe_o,
    input wire logic       dev_byte_strobe_oe,
    input wire logic       dev_byte_ready_oe,
    input wire logic [7:0] dev_port_byte_lines_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_release;
        $fell(srst_i);
    endsequence
    sequence s_roles_up;
        ##[1:4] (dev_byte_strobe_oe && dev_byte_strobe_o
            && dev_token_acknowledge_oe && dev_token_acknowledge_o);
    endsequence
    sequence s_ask;
        $fell(token_request);
    endsequence
    sequence s_granted;
        ##[1:6] !token_acknowledge;
    endsequence

    property p_float;
        s_release |-> !dev_token_request_oe && !dev_byte_ready_oe
            && !dev_byte_strobe_oe && !dev_token_acknowledge_oe;
    endproperty
    property p_drive_high;
        s_release |-> s_roles_up;
    endproperty
    property p_setup;
        $fell(dev_byte_strobe_o) && dev_byte_strobe_oe
            |-> $stable(dev_port_byte_lines_o);
    endproperty
    property p_hold;
        dev_byte_strobe_oe && !dev_byte_strobe_o && !$past(dev_byte_strobe_o)
            |-> $stable(dev_port_byte_lines_o);
    endproperty
    property p_release;
        $rose(dev_byte_strobe_o) && dev_byte_strobe_oe
            && $past(dev_byte_strobe_oe) |-> !$past(byte_ready);
    endproperty
    property p_ready_low;
        $fell(byte_strobe) |-> ##[1:5] !byte_ready;
    endproperty
    property p_ready_high;
        $rose(byte_strobe) && !byte_ready |-> ##[1:5] byte_ready;
    endproperty
    property p_next_byte;
        $fell(byte_strobe) |-> byte_ready;
    endproperty
    property p_grant;
        s_ask |-> s_granted;
    endproperty
    property p_yield;
        $fell(token_acknowledge) |-> ##[1:6] token_request;
    endproperty

    a_float: assert property (p_float)
        else $error("Link lines driven in reset");
    a_drive_high: assert property (p_drive_high)
        else $error("Role lines not driven high after reset");
    a_setup: assert property (p_setup)
        else $error("Byte changed as strobe fell");
    a_hold: assert property (p_hold)
        else $error("Byte changed while strobe low");
    a_release: assert property (p_release)
        else $error("Strobe raised before ready low");
    a_ready_low: assert property (p_ready_low)
        else $error("Ready did not fall after strobe");
    a_ready_high: assert property (p_ready_high)
        else $error("Ready did not rise after strobe");
    a_next_byte: assert property (p_next_byte)
        else $error("Strobe fell while ready low");
    a_grant: assert property (p_grant)
        else $error("Token request not acknowledged");
    a_yield: assert property (p_yield)
        else $error("Token request not withdrawn");
endmodule // bhc_link_properties

// >>> testbench/byte_handshake_comm_port_bench.sv
// Bench joining the device end and the far end over one link
`timescale 1ns/1ns
module byte_handshake_comm_port_bench;
    import bhc_pkg::*;
    logic              clk_i, srst_i, last_strobe;
    logic              dev_tx_valid, dev_tx_ready, dev_rx_valid;
    logic              far_tx_valid, far_tx_ready, far_rx_valid;
    logic              dev_want, dev_holds, far_want, far_holds;
    logic [WORD_W-1:0] dev_tx_data, dev_rx_data, far_tx_data, far_rx_data;
    logic [BYTE_W-1:0] wire_q[$];
    logic [WORD_W-1:0] rx_q[$];
    int                failures, comparisons;

    bhc_link_if link ();
    bhc_dev_port #(.PORT_NUM(0)) i_bhc_dev_port (.clk_i(clk_i),
        .srst_i(srst_i), .link(link), .tx_valid_i(dev_tx_valid),
        .tx_data_i(dev_tx_data), .tx_ready_o(dev_tx_ready),
        .rx_valid_o(dev_rx_valid), .rx_data_o(dev_rx_data),
        .want_token_i(dev_want), .holds_token_o(dev_holds));
    bhc_far_port #(.START_OUTPUT(1'b0)) i_bhc_far_port (.clk_i(clk_i),
        .srst_i(srst_i), .link(link), .tx_valid_i(far_tx_valid),
        .tx_data_i(far_tx_data), .tx_ready_o(far_tx_ready),
        .rx_valid_o(far_rx_valid), .rx_data_o(far_rx_data),
        .want_token_i(far_want), .holds_token_o(far_holds));
    bhc_link_properties i_bhc_link_properties (.clk_i(clk_i),
        .srst_i(srst_i), .token_request(link.token_request),
        .token_acknowledge(link.token_acknowledge),
        .byte_strobe(link.byte_strobe), .byte_ready(link.byte_ready),
        .dev_token_request_oe(link.dev_token_request_oe),
        .dev_token_acknowledge_o(link.dev_token_acknowledge_o),
        .dev_token_acknowledge_oe(link.dev_token_acknowledge_oe),
        .dev_byte_strobe_o(link.dev_byte_strobe_o),
        .dev_byte_strobe_oe(link.dev_byte_strobe_oe),
        .dev_byte_ready_oe(link.dev_byte_ready_oe),
        .dev_port_byte_lines_o(link.dev_port_byte_lines_o));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Bytes seen at each strobe fall and words delivered by either end
    always @(negedge clk_i) begin
        if (link.byte_strobe === 1'b0 && last_strobe === 1'b1)
            wire_q.push_back(link.port_byte_lines);
        last_strobe = link.byte_strobe;
        if (dev_rx_valid === 1'b1)
            rx_q.push_back(dev_rx_data);
        if (far_rx_valid === 1'b1)
            rx_q.push_back(far_rx_data);
    end

    task automatic cmp_word(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic expire(input bit stuck, input string what);
        if (stuck) begin
            failures++;
            $display("Error %s expected done seen timeout", what);
            conclude();
        end
    endtask

    task automatic do_reset();
        int n;
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        cmp_bit("strobe_oe", 1'b0, link.dev_byte_strobe_oe);
        cmp_bit("ready_oe", 1'b0, link.dev_byte_ready_oe);
        srst_i = 1'b0;
        for (n = 0; n < 4 && link.dev_byte_strobe_oe !== 1'b1; n++)
            @(negedge clk_i);
        expire(n == 4, "release");
        cmp_bit("ack_oe", 1'b1, link.dev_token_acknowledge_oe);
        cmp_bit("ack", 1'b1, link.token_acknowledge);
        cmp_bit("strobe", 1'b1, link.dev_byte_strobe_o);
        cmp_bit("dev_holds", 1'b1, dev_holds);
        cmp_bit("far_holds", 1'b0, far_holds);
    endtask

    task automatic send(input bit far_side, input logic [31:0] w);
        int n;
        @(negedge clk_i);
        if (far_side) begin
            far_tx_valid = 1'b1;
            far_tx_data = w;
        end else begin
            dev_tx_valid = 1'b1;
            dev_tx_data = w;
        end
        for (n = 0; n < 200 && (far_side ? far_tx_ready : dev_tx_ready)
            !== 1'b1; n++)
            @(negedge clk_i);
        expire(n == 200, "tx_ready");
        @(negedge clk_i);
        dev_tx_valid = 1'b0;
        far_tx_valid = 1'b0;
    endtask

    task automatic pair(input bit far_side, input logic [31:0] a, b);
        int n;
        logic [31:0] w[2];
        logic [31:0] wb;
        w = '{a, b};
        wire_q.delete();
        rx_q.delete();
        send(far_side, a);
        send(far_side, b);
        for (n = 0; n < 200 && rx_q.size() < 2; n++)
            @(negedge clk_i);
        expire(n == 200, "rx_valid");
        for (n = 0; n < 2; n++)
            cmp_word("rx_data", w[n], rx_q[n]);
        for (n = 0; n < 8; n++) begin
            wb = 32'(w[n/4][8*(n%4) +: 8]);
            cmp_word("wire_byte", wb, 32'(wire_q[n]));
        end
        wb = 32'(far_side ? dev_tx_ready : far_tx_ready);
        cmp_bit("idle_tx_ready", 1'b0, wb[0]);
    endtask

    task automatic swap(input bit to_far);
        int n;
        @(negedge clk_i);
        far_want = to_far;
        dev_want = !to_far;
        for (n = 0; n < 100 && (to_far ? far_holds : dev_holds) !== 1'b1;
            n++)
            @(negedge clk_i);
        expire(n == 100, "token");
        far_want = 1'b0;
        dev_want = 1'b0;
        for (n = 0; n < 20 && link.dev_byte_ready_oe !== to_far; n++)
            @(negedge clk_i);
        expire(n == 20, "turnaround");
        cmp_bit("strobe_oe", !to_far, link.dev_byte_strobe_oe);
        cmp_bit("data_oe", !to_far, link.dev_port_byte_lines_oe);
        cmp_bit("request_oe", to_far, link.dev_token_request_oe);
        cmp_bit("old_holds", 1'b0, to_far ? dev_holds : far_holds);
    endtask

    initial begin
        srst_i = 1'b1;
        last_strobe = 1'b1;
        {dev_tx_valid, far_tx_valid, dev_want, far_want} = 4'h0;
        dev_tx_data = 32'h0;
        far_tx_data = 32'h0;
        failures = 0;
        comparisons = 0;
        do_reset();
        pair(1'b0, 32'h11223344, 32'hA5C30FF0);
        swap(1'b1);
        pair(1'b1, 32'hDEADBEEF, 32'h000000FF);
        swap(1'b0);
        pair(1'b0, 32'hFFFFFFFF, 32'h80000001);
        swap(1'b1);
        do_reset();
        pair(1'b0, 32'h0F1E2D3C, 32'h00000000);
        conclude();
    end
endmodule // byte_handshake_comm_port_bench
